// ==== rtl/fts_cfg.svh ====
/*
 * Constants for the toggle status block: register offsets, field positions,
 * reset values and timing figures.
 * Assumes a 10 MHz core clock; included by bare name.
 */
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH

// core clock rate
`define FTS_CLK_MHZ 10

// times in microseconds, as figures
`define FTS_PROT_ERASE_TOGGLE_TIME_US 100
`define FTS_PROT_PROGRAM_TOGGLE_TIME_US 10
`define FTS_TIMING_LIMIT_TIME_US 400

// register byte offsets
`define FTS_CTRL_OFS 8'h00
`define FTS_TARGET_OFS 8'h04
`define FTS_OPLEN_OFS 8'h08
`define FTS_STATUS_OFS 8'h0C

// control fields
`define FTS_CTRL_GO_BIT 0
`define FTS_CTRL_ERASE_BIT 1
`define FTS_CTRL_PROT_BIT 2
`define FTS_CTRL_CONFLICT_BIT 3
`define FTS_CTRL_SUSPEND_BIT 4
`define FTS_CTRL_RESUME_BIT 5
`define FTS_CTRL_RESETCMD_BIT 6
`define FTS_CTRL_DATUM7_BIT 7

// target fields
`define FTS_TARGET_BANK_LSB 0
`define FTS_TARGET_SECTOR_LSB 8

// reset values
`define FTS_OPLEN_RESET 16'h0064
`define FTS_TARGET_RESET 16'h0000

`endif

// ==== rtl/fts_pkg.sv ====
/*
 * Types for the toggle status block.
 * Assumes fts_cfg.svh supplies the numeric constants.
 */
package fts_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_BUSY = 6'h02,
        ST_PROT = 6'h04,
        ST_SUSP = 6'h08,
        ST_SUSPPROG = 6'h10,
        ST_FAIL = 6'h20
    } fts_state_t;
endpackage

// ==== rtl/fts_status.sv ====
/*
 * Embedded-operation status reporting of a flash bank: drives the status byte
 * during status reads and keeps the two toggle bits, the failure bit and the
 * inverted-data poll bit. Software stands in for command decoding over AHB-Lite.
 * Assumes flash pins are asynchronous to clk; arrayData comes from clk logic.
 */
// Notes on behaviour
// - device toggle bit readable anywhere in the busy bank after the final write strobe
// - device toggle bit inverts each read while busy, then holds
// - erase of protected sector toggles for the protected erase time, then array reads
// - program of protected sector toggles for protected program time, then array reads
// - erase suspend stops device toggling; unselected sectors read array data
// - program in erase suspend toggles device bit until done; sector bit not used
// - toggle bits change only across a read strobe release and reassertion
// - sector erase bit toggles on selected sector reads while erasing or suspended
// - sector erase bit valid from the final write strobe rising edge
// - failure bit goes high when the operation exceeds its limit
// - programming a one over a zero halts and fails at the limit
// - reset command after failure returns to read or erase suspend read
// - poll bit reads 0 during erase, 1 when done or suspended; code gives 0 for an erase in ST_BUSY, else ~datum7 outside ST_SUSP, and a done read returns arrayData
`timescale 1ns/100ps
`include "fts_cfg.svh"
module fts_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN,
    input wire logic flashAvdN,
    input wire logic [1:0] flashBank,
    input wire logic [7:0] flashSector,
    input wire logic [7:0] arrayData,
    output logic [7:0] dqOut,
    output logic dqOe
);
    localparam logic [15:0] PROT_ERASE_CYCLES =
        16'(`FTS_PROT_ERASE_TOGGLE_TIME_US * `FTS_CLK_MHZ);
    localparam logic [15:0] PROT_PROG_CYCLES =
        16'(`FTS_PROT_PROGRAM_TOGGLE_TIME_US * `FTS_CLK_MHZ);
    localparam logic [15:0] LIMIT_CYCLES = 16'(`FTS_TIMING_LIMIT_TIME_US * `FTS_CLK_MHZ);

    // pin synchronisers: stage A is read only by stage B
    logic [13:0] syncA;
    logic [13:0] syncB;
    always_ff @(posedge clk) begin
        if (rst) begin
            syncA <= 14'h000F;
            syncB <= 14'h000F;
        end else begin
            syncA <= {flashSector, flashBank, flashAvdN, flashWeN, flashOeN, flashCeN};
            syncB <= syncA;
        end
    end
    logic ceN, oeN, weN, avdN;
    logic [1:0] pinBank;
    logic [7:0] pinSector;
    assign {pinSector, pinBank, avdN, weN, oeN, ceN} = syncB;

    logic readActive, readActivePrev, weNPrev;
    assign readActive = ~ceN & ~oeN;
    always_ff @(posedge clk) begin
        if (rst) begin
            readActivePrev <= 1'b0;
            weNPrev <= 1'b1;
        end else begin
            readActivePrev <= readActive;
            weNPrev <= weN;
        end
    end
    logic readEnd, weRise;
    assign readEnd = readActivePrev & ~readActive;
    assign weRise = ~weNPrev & weN;

    // address used by a read: taken while the address strobe is low or while chip enable is low with no read in progress
    logic [1:0] rdBank;
    logic [7:0] rdSector;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdBank <= 2'h0;
            rdSector <= 8'h00;
        end else if (~avdN | (~ceN & ~readActivePrev & ~readActive)) begin
            rdBank <= pinBank;
            rdSector <= pinSector;
        end
    end

    // AHB-Lite slave, zero wait states
    logic wrPend;
    logic [7:0] wrAddr;
    logic ctrlWr, targetWr, oplenWr;
    logic [31:0] hw;
    assign hw = hwdata;
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (hready) begin
            wrPend <= hsel & htrans[1] & hwrite;
            wrAddr <= haddr[7:0];
        end
    end
    assign ctrlWr = wrPend & (wrAddr == `FTS_CTRL_OFS);
    assign targetWr = wrPend & (wrAddr == `FTS_TARGET_OFS);
    assign oplenWr = wrPend & (wrAddr == `FTS_OPLEN_OFS);

    logic [15:0] target;
    logic [15:0] opLen;
    always_ff @(posedge clk) begin
        if (rst) begin
            target <= `FTS_TARGET_RESET;
            opLen <= `FTS_OPLEN_RESET;
        end else begin
            if (targetWr) begin
                target <= hw[15:0];
            end
            if (oplenWr) begin
                opLen <= hw[15:0];
            end
        end
    end

    // command armed by software, started by the final write strobe
    logic armed, armErase, armProt, armConflict, armDatum7;
    always_ff @(posedge clk) begin
        if (rst) begin
            armed <= 1'b0;
            armErase <= 1'b0;
            armProt <= 1'b0;
            armConflict <= 1'b0;
            armDatum7 <= 1'b0;
        end else if (ctrlWr & hw[`FTS_CTRL_GO_BIT]) begin
            armed <= 1'b1;
            armErase <= hw[`FTS_CTRL_ERASE_BIT];
            armProt <= hw[`FTS_CTRL_PROT_BIT];
            armConflict <= hw[`FTS_CTRL_CONFLICT_BIT];
            armDatum7 <= hw[`FTS_CTRL_DATUM7_BIT];
        end else if (weRise) begin
            armed <= 1'b0;
        end
    end
    logic start, suspendCmd, resumeCmd, resetCmd;
    assign start = armed & weRise;
    assign suspendCmd = ctrlWr & hw[`FTS_CTRL_SUSPEND_BIT];
    assign resumeCmd = ctrlWr & hw[`FTS_CTRL_RESUME_BIT];
    assign resetCmd = ctrlWr & hw[`FTS_CTRL_RESETCMD_BIT];

    // operation sequencer
    fts_pkg::fts_state_t state;
    logic opErase, opConflict, datum7, failFromSusp;
    logic [1:0] opBank;
    logic [7:0] eraseSector;
    logic [15:0] opCnt, eraseCnt, opEnd;
    logic opFails;
    assign opFails = opConflict | (opLen > LIMIT_CYCLES);
    assign opEnd = opFails ? LIMIT_CYCLES : opLen;
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= fts_pkg::ST_IDLE;
            opErase <= 1'b0;
            opConflict <= 1'b0;
            datum7 <= 1'b0;
            failFromSusp <= 1'b0;
            opBank <= 2'h0;
            eraseSector <= 8'h00;
            opCnt <= 16'h0000;
            eraseCnt <= 16'h0000;
        end else begin
            unique case (state)
                fts_pkg::ST_IDLE: begin
                    if (start) begin
                        opErase <= armErase;
                        opConflict <= armConflict;
                        datum7 <= armDatum7;
                        opBank <= target[`FTS_TARGET_BANK_LSB +: 2];
                        opCnt <= 16'h0000;
                        if (armErase) begin
                            eraseSector <= target[`FTS_TARGET_SECTOR_LSB +: 8];
                        end
                        state <= armProt ? fts_pkg::ST_PROT : fts_pkg::ST_BUSY;
                    end
                end
                fts_pkg::ST_PROT: begin
                    opCnt <= opCnt + 16'h0001;
                    if (opCnt + 16'h0001 >= (opErase ? PROT_ERASE_CYCLES
                                                      : PROT_PROG_CYCLES)) begin
                        state <= fts_pkg::ST_IDLE;
                    end
                end
                fts_pkg::ST_BUSY: begin
                    if (resetCmd) begin
                        state <= fts_pkg::ST_IDLE;
                    end else if (suspendCmd & opErase) begin
                        eraseCnt <= opCnt;
                        state <= fts_pkg::ST_SUSP;
                    end else if (opCnt + 16'h0001 >= opEnd) begin
                        failFromSusp <= 1'b0;
                        state <= opFails ? fts_pkg::ST_FAIL : fts_pkg::ST_IDLE;
                    end else begin
                        opCnt <= opCnt + 16'h0001;
                    end
                end
                fts_pkg::ST_SUSP: begin
                    if (resetCmd) begin
                        state <= fts_pkg::ST_IDLE;
                    end else if (resumeCmd) begin
                        opErase <= 1'b1;
                        opConflict <= 1'b0;
                        opCnt <= eraseCnt;
                        state <= fts_pkg::ST_BUSY;
                    end else if (start & ~armErase) begin
                        opConflict <= armConflict;
                        datum7 <= armDatum7;
                        opCnt <= 16'h0000;
                        state <= fts_pkg::ST_SUSPPROG;
                    end
                end
                fts_pkg::ST_SUSPPROG: begin
                    if (opCnt + 16'h0001 >= opEnd) begin
                        // a clean program must leave the suspended sector bit live
                        failFromSusp <= opFails;
                        state <= opFails ? fts_pkg::ST_FAIL : fts_pkg::ST_SUSP;
                    end else begin
                        opCnt <= opCnt + 16'h0001;
                    end
                end
                fts_pkg::ST_FAIL: begin
                    // stuck until the reset command; suspended erase is kept
                    if (resetCmd) begin
                        state <= failFromSusp ? fts_pkg::ST_SUSP : fts_pkg::ST_IDLE;
                        failFromSusp <= 1'b0;
                    end
                end
            endcase
        end
    end

    // read classification
    logic inBank, inSector, devToggling, secToggling, showStatus;
    assign inBank = rdBank == opBank;
    assign inSector = rdSector == eraseSector;
    assign devToggling = inBank & (state == fts_pkg::ST_BUSY | state == fts_pkg::ST_PROT
                         | state == fts_pkg::ST_SUSPPROG | state == fts_pkg::ST_FAIL);
    assign secToggling = inBank & inSector & opErase & ~failFromSusp
                         & (state == fts_pkg::ST_BUSY | state == fts_pkg::ST_SUSP
                            | state == fts_pkg::ST_FAIL);
    assign showStatus = inBank & (state != fts_pkg::ST_IDLE)
                        & ~(state == fts_pkg::ST_SUSP & ~inSector);

    // toggles step only when a read ends, so the host must release a strobe
    logic devToggle, secToggle;
    fts_toggle_bit devBit (
        .clk(clk),
        .rst(rst),
        .step(readEnd & devToggling),
        .value(devToggle)
    );
    fts_toggle_bit secBit (
        .clk(clk),
        .rst(rst),
        .step(readEnd & secToggling),
        .value(secToggle)
    );

    logic pollBit;
    always_comb begin
        if (opErase & state == fts_pkg::ST_BUSY) begin
            pollBit = 1'b0;
        end else if (state == fts_pkg::ST_SUSP) begin
            pollBit = 1'b1;
        end else begin
            pollBit = ~datum7;
        end
    end

    logic [7:0] next_dq;
    always_comb begin
        if (showStatus) begin
            next_dq = {pollBit, devToggle, state == fts_pkg::ST_FAIL, 2'b00, secToggle, 2'b00};
        end else begin
            next_dq = arrayData;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            dqOut <= 8'h00;
            dqOe <= 1'b0;
        end else begin
            dqOut <= next_dq;
            dqOe <= readActive;
        end
    end

    // register read data, registered in the address phase
    logic [31:0] next_rdata;
    always_comb begin
        unique case (haddr[7:0])
            `FTS_TARGET_OFS: next_rdata = {16'h0000, target};
            `FTS_OPLEN_OFS: next_rdata = {16'h0000, opLen};
            `FTS_STATUS_OFS: next_rdata = {16'h0000, opCnt[7:0], armed, secToggle,
                                           devToggle, 5'(state >> 1)} & 32'h0000_FFFF;
            default: next_rdata = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready & hsel & htrans[1] & ~hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end
endmodule

// ==== rtl/fts_toggle_bit.sv ====
/*
 * One status toggle flip-flop: inverts on each qualified completed read.
 * Assumes step is a one-cycle pulse on clk.
 */
`timescale 1ns/100ps
module fts_toggle_bit (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    output logic value
);
    always_ff @(posedge clk) begin
        if (rst) begin
            value <= 1'b0;
        end else if (step) begin
            value <= ~value;
        end
    end
endmodule

// ==== verif/fts_host_model.sv ====
/*
 * Host memory controller on the flash pins: write strobes and status reads.
 * Assumes dqOut settles within four clk of a pin change.
 */
`timescale 1ns/100ps
module fts_host_model (
    input wire logic clk,
    input wire logic [7:0] dqOut,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic avdN,
    output logic [1:0] bank,
    output logic [7:0] sector
);
    initial begin
        {ceN, oeN, weN, avdN} = 4'hF;
        bank = 2'h3;
        sector = 8'hFF;
    end
    task automatic strobe();
        @(posedge clk) weN <= 1'b0;
        ceN <= 1'b0;
        repeat (3) @(posedge clk);
        weN <= 1'b1; // final strobe rising edge
        ceN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // deselected address lines invert so a stale address never looks valid
    task automatic rd(input logic [1:0] b, input logic [7:0] s, output logic [7:0] v);
        @(posedge clk) bank <= b;
        sector <= s;
        ceN <= 1'b0;
        avdN <= 1'b0; // strobe in the same cycle as the address change
        @(posedge clk) avdN <= 1'b1;
        oeN <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk) v = dqOut;
        @(posedge clk) oeN <= 1'b1; // release between reads
        ceN <= 1'b1;
        bank <= ~b;
        sector <= ~s;
        repeat (4) @(posedge clk);
    endtask
    // no other bank is read between the two
    task automatic two(input logic [1:0] b, input logic [7:0] s, output logic [7:0] x, y);
        rd(b, s, x);
        rd(b, s, y);
    endtask
endmodule

// ==== verif/fts_status_checker.sv ====
/*
 * Port-level assertions for the toggle status block.
 * Assumes a single clk domain and bind from the testbench top file.
 */
`timescale 1ns/100ps
module fts_status_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic [7:0] arrayData,
    input wire logic [7:0] dqOut,
    input wire logic dqOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence rd_phase;
        hready && hsel && htrans[1] && !hwrite;
    endsequence
    // five cycles leaves margin over two sync stages and the output register
    sequence pins_low;
        (!flashCeN && !flashOeN)[*5];
    endsequence
    hresp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    ready_high_a: assert property (hreadyout)
        else $error("hreadyout low");
    reset_clears_a: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> hrdata == 32'h0 && dqOut == 8'h0 && !dqOe)
        else $error("outputs not cleared by reset");
    ctrl_reads_zero_a: assert property (rd_phase ##0 haddr[7:0] == 8'h00 |=> hrdata == 32'h0)
        else $error("control read not zero");
    unmapped_zero_a: assert property (rd_phase ##0 haddr[7:0] >= 8'h10 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    oe_on_a: assert property (pins_low |-> dqOe)
        else $error("data not driven during read");
    oe_off_a: assert property (flashOeN [*5] |-> !dqOe)
        else $error("data driven with output enable high");
    ce_off_a: assert property (flashCeN [*5] |-> !dqOe)
        else $error("data driven with chip enable high");
    status_spare_a: assert property (dqOe && dqOut != $past(arrayData) |->
        dqOut[4:3] == 2'h0 && dqOut[1:0] == 2'h0)
        else $error("unused status bits set");
endmodule

// ==== verif/testbench.sv ====
/*
 * Self-checking bench for the toggle status block.
 * Assumes fts_host_model drives the flash pins and the ahb task drives AHB-Lite single transfers.
 */
`timescale 1ns/100ps
`include "fts_cfg.svh"
module testbench;
    logic clk, rst, hsel, hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata;
    logic [7:0] arrayData;
    wire hreadyout, hresp, dqOe, ceN, oeN, weN, avdN;
    wire [31:0] hrdata;
    wire [7:0] dqOut, sector;
    wire [1:0] bank;
    int failures, n_checks, cycles;
    fts_status fts_status_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashAvdN(avdN),
        .flashBank(bank), .flashSector(sector), .arrayData(arrayData),
        .dqOut(dqOut), .dqOe(dqOe));
    fts_host_model fts_host_model_i (.clk(clk), .dqOut(dqOut), .ceN(ceN), .oeN(oeN),
        .weN(weN), .avdN(avdN), .bank(bank), .sector(sector));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk) hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic go(input logic [7:0] c);
        logic [31:0] q;
        ahb(1'b1, `FTS_CTRL_OFS, {24'h0, c}, q);
        fts_host_model_i.strobe();
    endtask
    task automatic t_program();
        logic [7:0] a, b;
        logic [31:0] q;
        ahb(1'b1, `FTS_TARGET_OFS, 32'h1, q);
        ahb(1'b1, `FTS_OPLEN_OFS, 32'h12C, q);
        go(8'h81);
        fts_host_model_i.two(2'h1, 8'h00, a, b);
        check(a[6] ^ b[6], 1'b1);
        check({a[7], a[5], a[2], b[2]}, 4'h0);
        fts_host_model_i.rd(2'h2, 8'h00, a);
        check(a, arrayData);
        ahb(1'b0, `FTS_STATUS_OFS, 32'h0, q);
        check(q[0], 1'b1);
        repeat (300) @(posedge clk);
        fts_host_model_i.two(2'h1, 8'h00, a, b);
        check({a, b}, {arrayData, arrayData});
    endtask
    task automatic t_erase();
        logic [7:0] a, b;
        logic [31:0] q;
        ahb(1'b1, `FTS_TARGET_OFS, 32'h500, q);
        ahb(1'b1, `FTS_OPLEN_OFS, 32'h320, q);
        go(8'h03);
        fts_host_model_i.two(2'h0, 8'h05, a, b);
        check({a[6] ^ b[6], a[2] ^ b[2], a[7], b[5]}, 4'hC);
        fts_host_model_i.two(2'h0, 8'h06, a, b);
        check({a[6] ^ b[6], a[2] ^ b[2]}, 2'h2);
        ahb(1'b1, `FTS_CTRL_OFS, 32'h10, q);
        fts_host_model_i.two(2'h0, 8'h05, a, b);
        check({a[6] ^ b[6], a[2] ^ b[2], b[7]}, 3'h3);
        fts_host_model_i.rd(2'h0, 8'h06, a);
        check(a, arrayData);
        go(8'h01);
        fts_host_model_i.two(2'h0, 8'h05, a, b);
        check(a[6] ^ b[6], 1'b1);
        repeat (820) @(posedge clk);
        fts_host_model_i.two(2'h0, 8'h05, a, b);
        check({a[6] ^ b[6], a[2] ^ b[2]}, 2'h1);
        ahb(1'b1, `FTS_CTRL_OFS, 32'h20, q);
        repeat (1700) @(posedge clk);
        fts_host_model_i.rd(2'h0, 8'h05, a);
        check(a, arrayData);
    endtask
    // protected erase, then protected program, each toggles only for its fixed time
    task automatic t_protect();
        logic [7:0] a, b;
        for (int i = 0; i < 2; i++) begin
            go(i == 0 ? 8'h07 : 8'h05);
            fts_host_model_i.two(2'h0, 8'h05, a, b);
            check(a[6] ^ b[6], 1'b1);
            repeat (i == 0 ? 1000 : 100) @(posedge clk);
            fts_host_model_i.rd(2'h0, 8'h05, a);
            check(a, arrayData);
        end
    endtask
    task automatic t_fail();
        logic [7:0] a, b;
        logic [31:0] q;
        ahb(1'b1, `FTS_TARGET_OFS, 32'h1, q);
        go(8'h09);
        fts_host_model_i.two(2'h1, 8'h00, a, b);
        check({a[6] ^ b[6], b[5]}, 2'h2);
        repeat (4000) @(posedge clk);
        fts_host_model_i.two(2'h1, 8'h00, a, b);
        check({a[6] ^ b[6], a[5], b[5]}, 3'h7);
        ahb(1'b1, `FTS_CTRL_OFS, 32'h40, q);
        fts_host_model_i.rd(2'h1, 8'h00, a);
        check(a, arrayData);
        ahb(1'b0, 8'h40, 32'h0, q);
        check(q, 32'h0);
        ahb(1'b0, `FTS_CTRL_OFS, 32'h0, q);
        check(q, 32'h0);
    endtask
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        arrayData = 8'h5B;
        rst = 1'b1;
        failures = 0;
        n_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_program();
        t_erase();
        t_protect();
        t_fail();
        end_sim();
    end
endmodule
bind fts_status fts_status_checker fts_status_checker_i (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flashCeN(flashCeN),
    .flashOeN(flashOeN), .arrayData(arrayData), .dqOut(dqOut), .dqOe(dqOe));
